// file: common/mocr_pkg.sv
// Purpose: Shared constants and carriers for the monitor offset/config bank
// Assumes: APB with 32-bit data, register index times four is the byte address
// Notes:   Register indices, reset values, field positions, measurement width and slot timing live here
package mocr_pkg;

   // ==========================================================
   // Bus and register map
   localparam int unsigned ADDR_W  = 12;
   localparam logic [7:0]  IDX_LOCAL_OFS = 8'h71;
   localparam logic [7:0]  IDX_REM2_OFS  = 8'h72;
   localparam logic [7:0]  IDX_CFG2      = 8'h73;
   localparam logic [7:0]  RST_OFS       = 8'h00;
   localparam logic [7:0]  RST_CFG2      = 8'h00;

   // ==========================================================
   // Second configuration register fields
   localparam int unsigned CFG2_PRES_EN = 0;
   localparam int unsigned CFG2_FAN_LO  = 1;
   localparam int unsigned CFG2_AVG     = 4;
   localparam int unsigned CFG2_ATTENUATOR_BYPASS    = 5;
   localparam int unsigned CFG2_SINGLE_CHANNEL_CONVERSION    = 6;

   // ==========================================================
   // Measurement and conversion timing
   localparam int unsigned TEMP_W         = 10;
   localparam int unsigned OFS_SHIFT_FINE = 1;
   localparam int unsigned OFS_SHIFT_WIDE = 2;
   localparam int unsigned NUM_CHAN       = 8;
   localparam int unsigned SLOT_CYCLES    = 1600;
   localparam int unsigned AVG_FACTOR     = 16;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } mocr_apb_req_s;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } mocr_apb_rsp_s;

   typedef struct packed {
      logic              valid;
      logic [TEMP_W-1:0] value;
   } mocr_meas_s;

   typedef struct packed {
      logic [7:0]  local_ofs;
      logic [7:0]  rem2_ofs;
      logic        pres_en;
      logic [2:0]  fan_seen;
      logic        avg_off;
      logic        attenuator_bypass_all;
      logic        single_channel_conversion_single;
      logic [3:0]  attenuator_bypass_out;
      logic [31:0] rdata;
   } mocr_regs_s;

endpackage

// file: logic/mocr_offset_add.sv
// Purpose: Adds a signed temperature offset to one raw measurement
// Assumes: Raw value is unsigned in quarter-degree steps
// Notes:   One cycle of latency; result saturates at both ends
module mocr_offset_add
   import mocr_pkg::*;
#(
   parameter int unsigned TW = TEMP_W
)(
   input  wire logic                 clk,       // System clock
   input  wire logic                 rst,       // Sync reset, high
   input  wire mocr_pkg::mocr_meas_s raw,       // Raw measurement
   input  wire logic [7:0]           offset,    // Signed offset
   input  wire logic                 fine_sel,  // Offset scale select
   output mocr_pkg::mocr_meas_s      corrected  // Offset-corrected result
);

   typedef struct packed {
      mocr_meas_s res;
   } mocr_add_st_s;

   mocr_add_st_s st_q;
   mocr_add_st_s st_d;

   function automatic logic [TW-1:0] apply(input logic [TW-1:0] v,
                                           input logic [7:0] ofs,
                                           input logic fine);
      logic signed [TW+3:0] sh;
      logic signed [TW+3:0] sum;
      sh  = fine ? (TW+4)'($signed(ofs)) <<< OFS_SHIFT_FINE
                 : (TW+4)'($signed(ofs)) <<< OFS_SHIFT_WIDE;
      sum = $signed({4'h0, v}) + sh;
      if (sum < 0)
         apply = '0;
      else if (sum > $signed({4'h0, {TW{1'b1}}}))
         apply = {TW{1'b1}};
      else
         apply = sum[TW-1:0];
   endfunction

   always_comb
   begin
      st_d           = st_q;
      st_d.res.valid = raw.valid;
      if (raw.valid)
         st_d.res.value = apply(raw.value, offset, fine_sel);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign corrected = st_q.res;

endmodule

// file: logic/mocr_regs.sv
// Purpose: Offset and second configuration registers of the hardware monitor
// Assumes: Lock, scale select, per-channel attenuator and channel select
//          come from neighbouring register blocks as levels
// Notes:   APB slave with no wait states; read data is captured in setup
//
// How it works
// - Local offset is an 8-bit read/write register, reset 0, added to every local reading.
// - Remote 2 offset is an 8-bit read/write register, reset 0, added to that reading.
// - The offset scale follows the scale select from the fifth config register.
// - With the lock set, writes to both offsets and the config register are dropped.
// - With presence detect on, bits 3 to 1 report 4-wire fans on the tach inputs.
// - Bits 1, 2 and 3 are read-only fan flags for tach inputs one, two and three.
// - Averaging off makes each channel slot sixteen times shorter.
// - Attenuator bypass removes attenuation from the four scaled voltage inputs.
// - Attenuators may also be removed one by one from the fourth config register.
// - Single-channel mode repeats one channel instead of cycling.
// - The single channel is chosen by bits 7 to 5 of the first tach minimum high byte.
module mocr_regs
   import mocr_pkg::*;
#(
   parameter int unsigned SLOT = SLOT_CYCLES
)(
   input  wire logic                    clk,                       // System clock
   input  wire logic                    rst,                       // Sync reset, high
   input  wire mocr_pkg::mocr_apb_req_s apb_req,                   // APB request
   output mocr_pkg::mocr_apb_rsp_s      apb_rsp,                   // APB answer
   input  wire logic                    config_lock,               // Lock from config 1
   input  wire logic                    offset_fine_sel,           // Scale from config 5
   input  wire logic [3:0]              attenuator_bypass_chan_remove,          // Config 4 bits 7:4
   input  wire logic [2:0]              single_chan_select,        // Tach min high 7:5
   input  wire logic [2:0]              fan_four_wire_in,          // Fan sense per tach
   input  wire mocr_pkg::mocr_meas_s    local_raw,                 // Raw local reading
   input  wire mocr_pkg::mocr_meas_s    remote_two_raw,            // Raw remote 2 reading
   output mocr_pkg::mocr_meas_s         local_temp,                // Corrected local
   output mocr_pkg::mocr_meas_s         remote_two_temp,           // Corrected remote 2
   output logic                         averaging_disable,         // Averaging off
   output logic [3:0]                   attenuator_bypass,         // Per-input bypass
   output logic                         single_channel_conversion, // One-channel mode
   output logic [2:0]                   single_channel_conversion_channel,              // Channel converting
   output logic                         single_channel_conversion_start                 // Conversion start
);

   // ==========================================================
   // Address decode

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] idx);
      hit = (a == {2'b00, idx, 2'b00});
   endfunction

   mocr_regs_s st_q;
   mocr_regs_s st_d;

   logic setup;
   logic access;
   logic wr_ok;
   logic mapped;

   assign setup  = apb_req.psel && !apb_req.penable;
   assign access = apb_req.psel && apb_req.penable;
   assign mapped = hit(apb_req.paddr, IDX_LOCAL_OFS)
                || hit(apb_req.paddr, IDX_REM2_OFS)
                || hit(apb_req.paddr, IDX_CFG2);
   // Locked writes complete normally on the bus but change nothing
   assign wr_ok  = access && apb_req.pwrite && !config_lock;

   // ==========================================================
   // Register state

   always_comb
   begin
      st_d = st_q;

      if (wr_ok && hit(apb_req.paddr, IDX_LOCAL_OFS))
         st_d.local_ofs = apb_req.pwdata[7:0];
      if (wr_ok && hit(apb_req.paddr, IDX_REM2_OFS))
         st_d.rem2_ofs = apb_req.pwdata[7:0];
      // Bits 3:1 and 7 are not writable; the reserved bit is never stored
      if (wr_ok && hit(apb_req.paddr, IDX_CFG2))
      begin
         st_d.pres_en     = apb_req.pwdata[CFG2_PRES_EN];
         st_d.avg_off     = apb_req.pwdata[CFG2_AVG];
         st_d.attenuator_bypass_all    = apb_req.pwdata[CFG2_ATTENUATOR_BYPASS];
         st_d.single_channel_conversion_single = apb_req.pwdata[CFG2_SINGLE_CHANNEL_CONVERSION];
      end

      if (st_q.pres_en)
         st_d.fan_seen = fan_four_wire_in;
      else
         st_d.fan_seen = 3'h0;

      st_d.attenuator_bypass_out = {4{st_q.attenuator_bypass_all}} | attenuator_bypass_chan_remove;

      if (setup)
      begin
         st_d.rdata = 32'h0;
         if (hit(apb_req.paddr, IDX_LOCAL_OFS))
            st_d.rdata[7:0] = st_q.local_ofs;
         else if (hit(apb_req.paddr, IDX_REM2_OFS))
            st_d.rdata[7:0] = st_q.rem2_ofs;
         else if (hit(apb_req.paddr, IDX_CFG2))
            st_d.rdata[7:0] = {1'b0, st_q.single_channel_conversion_single, st_q.attenuator_bypass_all,
                               st_q.avg_off, st_q.fan_seen,
                               st_q.pres_en};
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q           <= '0;
         st_q.local_ofs <= RST_OFS;
         st_q.rem2_ofs  <= RST_OFS;
         st_q.pres_en   <= RST_CFG2[CFG2_PRES_EN];
      end
      else
         st_q <= st_d;
   end

   // ==========================================================
   // Bus answer

   assign apb_rsp.pready  = access;
   assign apb_rsp.prdata  = st_q.rdata;
   assign apb_rsp.pslverr = access && !mapped;

   assign averaging_disable         = st_q.avg_off;
   assign attenuator_bypass         = st_q.attenuator_bypass_out;
   assign single_channel_conversion = st_q.single_channel_conversion_single;

   // ==========================================================
   // Offset adders and conversion pacing

   mocr_offset_add #(
      .TW (TEMP_W)
   ) u_local_add (
      .clk       (clk),
      .rst       (rst),
      .raw       (local_raw),
      .offset    (st_q.local_ofs),
      .fine_sel  (offset_fine_sel),
      .corrected (local_temp)
   );

   mocr_offset_add #(
      .TW (TEMP_W)
   ) u_rem2_add (
      .clk       (clk),
      .rst       (rst),
      .raw       (remote_two_raw),
      .offset    (st_q.rem2_ofs),
      .fine_sel  (offset_fine_sel),
      .corrected (remote_two_temp)
   );

   mocr_single_channel_conversion_ctl #(
      .SLOT (SLOT),
      .NCH  (NUM_CHAN)
   ) u_single_channel_conversion (
      .clk         (clk),
      .rst         (rst),
      .avg_off     (st_q.avg_off),
      .single_mode (st_q.single_channel_conversion_single),
      .single_sel  (single_chan_select),
      .channel     (single_channel_conversion_channel),
      .start       (single_channel_conversion_start)
   );

   // ==========================================================
   // Checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic cfg_rd;
   assign cfg_rd = access && !apb_req.pwrite && hit(apb_req.paddr, IDX_CFG2);

   wr_local_offset_a: assert property (
      wr_ok && hit(apb_req.paddr, IDX_LOCAL_OFS)
      |=> st_q.local_ofs == $past(apb_req.pwdata[7:0]))
      else $error("local offset write not stored");

   wr_rem2_offset_a: assert property (
      wr_ok && hit(apb_req.paddr, IDX_REM2_OFS)
      |=> st_q.rem2_ofs == $past(apb_req.pwdata[7:0]))
      else $error("remote 2 offset write not stored");

   locked_write_a: assert property (
      access && apb_req.pwrite && config_lock
      |=> $stable(st_q.local_ofs) && $stable(st_q.rem2_ofs)
          && $stable(st_q.avg_off) && $stable(st_q.single_channel_conversion_single))
      else $error("locked write changed a register");

   fan_follow_a: assert property (
      st_q.pres_en && $stable(st_q.pres_en)
      |-> st_q.fan_seen == $past(fan_four_wire_in))
      else $error("fan flags do not follow sense inputs");

   fan_idle_a: assert property (
      !st_q.pres_en ##1 !st_q.pres_en |-> st_q.fan_seen == 3'h0)
      else $error("fan flag set while detection off");

   cfg_read_a: assert property (
      cfg_rd && $stable(st_q.fan_seen) && $stable(st_q.pres_en)
      |-> apb_rsp.prdata[7:0] == {1'b0, st_q.single_channel_conversion_single, st_q.attenuator_bypass_all,
                                  st_q.avg_off, st_q.fan_seen, st_q.pres_en})
      else $error("config read data wrong");

   reserved_zero_a: assert property (
      cfg_rd |-> apb_rsp.prdata[7] == 1'b0)
      else $error("reserved bit reads nonzero");

   unmapped_err_a: assert property (
      access |-> apb_rsp.pready && (apb_rsp.pslverr == !mapped))
      else $error("bad answer to access phase");

   attenuator_bypass_merge_a: assert property (
      ##1 attenuator_bypass == ({4{$past(st_q.attenuator_bypass_all)}} | $past(attenuator_bypass_chan_remove)))
      else $error("attenuator bypass mismatch");

   local_latency_a: assert property (
      local_raw.valid |=> local_temp.valid)
      else $error("corrected local result missing");

   single_chan_a: assert property (
      single_channel_conversion_start && $past(st_q.single_channel_conversion_single)
      |-> single_channel_conversion_channel == $past(single_chan_select))
      else $error("single mode picked wrong channel");

   start_pulse_a: assert property (
      single_channel_conversion_start |=> !single_channel_conversion_start)
      else $error("start pulse longer than one cycle");

   cov_locked_write_c: cover property (access && apb_req.pwrite && config_lock);
   cov_single_single_channel_conversion_c: cover property (single_channel_conversion_start && st_q.single_channel_conversion_single);
   cov_fan_seen_c: cover property (st_q.pres_en && st_q.fan_seen != 3'h0);
   cov_fast_single_channel_conversion_c: cover property (single_channel_conversion_start && st_q.avg_off);

endmodule

// file: logic/mocr_single_channel_conversion_ctl.sv
// Purpose: Paces conversions round the channels or on one chosen channel
// Assumes: The converter starts a conversion on each start pulse
// Notes:   Averaging off shortens each slot by the averaging factor
module mocr_single_channel_conversion_ctl
   import mocr_pkg::*;
#(
   parameter int unsigned SLOT = SLOT_CYCLES,
   parameter int unsigned NCH  = NUM_CHAN
)(
   input  wire logic       clk,         // System clock
   input  wire logic       rst,         // Sync reset, high
   input  wire logic       avg_off,     // Averaging disabled
   input  wire logic       single_mode, // Stay on one channel
   input  wire logic [2:0] single_sel,  // Channel for single mode
   output logic      [2:0] channel,     // Channel being converted
   output logic            start        // One-cycle start pulse
);

   localparam logic [15:0] LIM_AVG  = 16'(SLOT - 1);
   localparam logic [15:0] LIM_FAST = 16'(SLOT / AVG_FACTOR - 1);

   typedef struct packed {
      logic [15:0] cnt;
      logic [2:0]  chan;
      logic        start;
   } mocr_single_channel_conversion_st_s;

   mocr_single_channel_conversion_st_s st_q;
   mocr_single_channel_conversion_st_s st_d;

   always_comb
   begin
      st_d       = st_q;
      st_d.start = 1'b0;
      if (st_q.cnt >= (avg_off ? LIM_FAST : LIM_AVG))
      begin
         st_d.cnt   = '0;
         st_d.start = 1'b1;
         if (single_mode)
            st_d.chan = single_sel;
         else if (st_q.chan == 3'(NCH - 1))
            st_d.chan = '0;
         else
            st_d.chan = st_q.chan + 3'h1;
      end
      else
         st_d.cnt = st_q.cnt + 16'h1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign channel = st_q.chan;
   assign start   = st_q.start;

endmodule

// file: verification/mocr_regs_tb.sv
// Purpose: Self-checking bench for the offset and second configuration registers
// Assumes: APB slave answers in the first access cycle; slot shortened to 32 cycles
// Notes:   Random stimulus from a fixed seed with corner values mixed in
module mocr_regs_tb;
   import mocr_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // Signals
   localparam int unsigned SLOT_TB = 32;
   logic          clk;
   logic          rst;
   mocr_apb_req_s req;
   mocr_apb_rsp_s rsp;
   logic          config_lock;
   logic          offset_fine_sel;
   logic [3:0]    attenuator_bypass_chan_remove;
   logic [2:0]    single_chan_select;
   logic [2:0]    fan_four_wire_in;
   mocr_meas_s    local_raw;
   mocr_meas_s    remote_two_raw;
   mocr_meas_s    local_temp;
   mocr_meas_s    remote_two_temp;
   logic          averaging_disable;
   logic [3:0]    attenuator_bypass;
   logic          single_channel_conversion;
   logic [2:0]    single_channel_conversion_channel;
   logic          single_channel_conversion_start;
   int            n_fail;
   int            compares;
   integer        seed;
   logic [7:0]    lo;
   logic [7:0]    r2;
   logic [7:0]    cfg;
   logic [9:0]    a;
   logic [9:0]    b;
   logic [2:0]    ch0;
   logic [2:0]    ch1;
   int            gap;

   mocr_regs #(.SLOT(SLOT_TB)) u_dut (
      .clk                       (clk),
      .rst                       (rst),
      .apb_req                   (req),
      .apb_rsp                   (rsp),
      .config_lock               (config_lock),
      .offset_fine_sel           (offset_fine_sel),
      .attenuator_bypass_chan_remove          (attenuator_bypass_chan_remove),
      .single_chan_select        (single_chan_select),
      .fan_four_wire_in          (fan_four_wire_in),
      .local_raw                 (local_raw),
      .remote_two_raw            (remote_two_raw),
      .local_temp                (local_temp),
      .remote_two_temp           (remote_two_temp),
      .averaging_disable         (averaging_disable),
      .attenuator_bypass         (attenuator_bypass),
      .single_channel_conversion (single_channel_conversion),
      .single_channel_conversion_channel              (single_channel_conversion_channel),
      .single_channel_conversion_start                (single_channel_conversion_start)
   );

   always #2.5 clk = ~clk;

   // ==========================================================
   // Checking and expectations
   task automatic conclude();
      if (n_fail == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_meas(input mocr_meas_s got, input logic [TEMP_W-1:0] exp);
      compares++;
      if (got !== {1'b1, exp})
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, {1'b1, exp});
      end
   endtask

   // Offset scaled by the select, then clamped to the result range
   function automatic logic [TEMP_W-1:0] corr(logic [9:0] raw, logic [7:0] ofs, logic fine);
      int v;
      v = int'(raw) + int'($signed(ofs)) * (fine ? 2 : 4);
      if (v < 0)
         v = 0;
      if (v > 1023)
         v = 1023;
      return TEMP_W'(v);
   endfunction

   function automatic logic [31:0] cfg_exp(logic [7:0] c, logic [2:0] fan);
      return {24'h0, 1'b0, c[6:4], (c[0] ? fan : 3'b000), c[0]};
   endfunction

   // ==========================================================
   // Bus master: request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= wr;
      req.paddr   <= {2'b00, idx, 2'b00};
      req.pwdata  <= wd;
      @(posedge clk);
      req.penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (rsp.pready !== 1'b1 && n < 20);
      chk_word(32'(rsp.pready), 32'h1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      logic        e;
      apb(1'b1, idx, {$random(seed)} & 32'hffffff00 | 32'(d), rd, e);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic experr);
      logic [31:0] rd;
      logic        e;
      apb(1'b0, idx, 32'h0, rd, e);
      chk_word(rd, exp);
      chk_word(32'(e), 32'(experr));
   endtask

   // Finds one start pulse, then counts edges up to the next
   task automatic pace();
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (single_channel_conversion_start !== 1'b1 && n < 200);
      ch0 = single_channel_conversion_channel;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (single_channel_conversion_start !== 1'b1 && n < 200);
      gap = n;
      ch1 = single_channel_conversion_channel;
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      req = '0;
      config_lock = 1'b0;
      offset_fine_sel = 1'b0;
      attenuator_bypass_chan_remove = 4'h0;
      single_chan_select = 3'h0;
      fan_four_wire_in = 3'h0;
      local_raw = '0;
      remote_two_raw = '0;
      n_fail = 0;
      compares = 0;
      seed = 32'h0771;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd_chk(IDX_LOCAL_OFS, 32'h0, 1'b0);
      rd_chk(IDX_REM2_OFS, 32'h0, 1'b0);
      rd_chk(IDX_CFG2, 32'h0, 1'b0);
      for (int i = 0; i < 6; i++)
      begin
         lo = (i == 0) ? 8'h80 : 8'($random(seed));
         r2 = (i == 0) ? 8'h7f : 8'($random(seed));
         a = (i == 0) ? 10'h000 : 10'($random(seed));
         b = (i == 0) ? 10'h3ff : 10'($random(seed));
         offset_fine_sel <= i[0];
         wr(IDX_LOCAL_OFS, lo);
         wr(IDX_REM2_OFS, r2);
         rd_chk(IDX_LOCAL_OFS, 32'(lo), 1'b0);
         rd_chk(IDX_REM2_OFS, 32'(r2), 1'b0);
         @(posedge clk);
         local_raw <= '{1'b1, a};
         remote_two_raw <= '{1'b1, b};
         @(posedge clk);
         local_raw <= '{1'b0, a};
         remote_two_raw <= '{1'b0, b};
         #1;
         chk_meas(local_temp, corr(a, lo, i[0]));
         chk_meas(remote_two_temp, corr(b, r2, i[0]));
      end
      for (int i = 0; i < 8; i++)
      begin
         // Reserved bit 7 is always written back as zero
         cfg = ((i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed))) & 8'h7f;
         fan_four_wire_in <= 3'($random(seed));
         attenuator_bypass_chan_remove <= 4'($random(seed));
         wr(IDX_CFG2, cfg);
         repeat (3) @(posedge clk);
         if (cfg[0])
            rd_chk(IDX_CFG2, cfg_exp(cfg, fan_four_wire_in), 1'b0);
         else
            rd_chk(IDX_CFG2, cfg_exp(cfg, fan_four_wire_in), 1'b0);
         chk_word(32'(averaging_disable), 32'(cfg[4]));
         chk_word(32'(single_channel_conversion), 32'(cfg[6]));
         chk_word(32'(attenuator_bypass), 32'({4{cfg[5]}} | attenuator_bypass_chan_remove));
      end
      // Locked writes must leave all three registers as they were
      config_lock <= 1'b1;
      wr(IDX_LOCAL_OFS, ~lo);
      wr(IDX_REM2_OFS, ~r2);
      wr(IDX_CFG2, ~cfg & 8'h7f);
      rd_chk(IDX_LOCAL_OFS, 32'(lo), 1'b0);
      rd_chk(IDX_REM2_OFS, 32'(r2), 1'b0);
      rd_chk(IDX_CFG2, cfg_exp(cfg, fan_four_wire_in), 1'b0);
      config_lock <= 1'b0;
      rd_chk(8'h70, 32'h0, 1'b1);
      rd_chk(8'h74, 32'h0, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
         single_chan_select <= 3'($random(seed));
         cfg = {1'b0, k[1], 1'b0, k[0], 4'h0};
         wr(IDX_CFG2, cfg);
         pace();
         pace();
         chk_word(32'(gap), k[0] ? 32'(SLOT_TB / AVG_FACTOR) : 32'(SLOT_TB));
         if (k[1])
            chk_word(32'(ch1), 32'(single_chan_select));
         else
            chk_word(32'(ch1), 32'(3'(ch0 + 3'd1)));
         if (k[1])
            chk_word(32'(ch0), 32'(ch1));
      end
      conclude();
   end

   // Cut a hang short well beyond the expected run length
   initial
   begin
      #(5 * 30000);
      n_fail++;
      conclude();
   end
endmodule
